// ===== hdl/cdm_data_move.sv
// data-move execution unit: register file, flags, memory access, axi4-lite control
// Operation
// - registers usable as byte or word operands
// - immediate field of 3, 8 or 16 bits
// - base plus 8- or 16-bit displacement
// - absolute address in 8- or 16-bit form
// - negative and zero follow moved value
// - overflow cleared; carry, half, mask kept
// - byte load, then pointer plus 1, 6 states
// - word load, then pointer plus 2, 6 states
// - pointer minus 1, then byte store, 6 states
// - pointer minus 2, then word store, 6 states
// - pop: load from stack, stack plus 2
`timescale 1ns/1ps
`default_nettype none

module cdm_data_move
   import cdm_pkg::*;
(
   input  wire  logic        aclk,        // system clock
   input  wire  logic        aresetn,     // synchronous reset, active low
   input  wire  logic [7:0]  awaddr,      // write address
   input  wire  logic        awvalid,     // write address valid
   output var   logic        awready,     // write address ready
   input  wire  logic [31:0] wdata,       // write data
   input  wire  logic [3:0]  wstrb,       // write byte strobes
   input  wire  logic        wvalid,      // write data valid
   output var   logic        wready,      // write data ready
   output var   logic [1:0]  bresp,       // write response
   output var   logic        bvalid,      // write response valid
   input  wire  logic        bready,      // write response ready
   input  wire  logic [7:0]  araddr,      // read address
   input  wire  logic        arvalid,     // read address valid
   output var   logic        arready,     // read address ready
   output var   logic [31:0] rdata,       // read data
   output var   logic [1:0]  rresp,       // read response
   output var   logic        rvalid,      // read data valid
   input  wire  logic        rready,      // read data ready
   output var   logic        mem_req,     // memory access strobe, one cycle
   output var   logic        mem_we,      // access is a write
   output var   logic        mem_word,    // access is 16 bits wide
   output var   logic [15:0] mem_addr,    // access address
   output var   logic [15:0] mem_wdata,   // store data, byte in low bits
   input  wire  logic [15:0] mem_rdata,   // load data, the cycle after mem_req
   output var   logic        busy         // instruction under way
);

   // helpers
   function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                           input logic [15:0] new_v,
                                           input logic [1:0]  strb);
      logic [15:0] res;
      res = old_v;
      if (strb[0]) res[7:0]  = new_v[7:0];
      if (strb[1]) res[15:8] = new_v[15:8];
      return res;
   endfunction

   // byte register: index bit 3 picks the low half of the word register
   function automatic logic [7:0] byte_of(input logic [15:0] w, input logic low);
      return low ? w[7:0] : w[15:8];
   endfunction

   function automatic logic [2:0] op_states(input cdm_op_type op, input logic word,
                                            input logic short);
      logic [2:0] n;
      n = NST_LONG;
      unique case (op)
         OP_MOV_IMM:           n = word ? NST_MID : NST_SHORT;
         OP_MOV_REG:           n = NST_SHORT;
         OP_LD_IND, OP_ST_IND: n = NST_MID;
         OP_LD_ABS, OP_ST_ABS: n = short ? NST_MID : NST_LONG;
         default:              n = NST_LONG;
      endcase
      return n;
   endfunction

   // state
   logic [15:0]  gr_r [8];
   logic [7:0]   cond_r;
   logic [31:0]  insn_r;
   logic [15:0]  opnd_r;
   cdm_fsm_type  fsm_r;
   logic [2:0]   cnt_r;
   logic [2:0]   nstate_r;
   logic         busy_r;

   logic         aw_hold_r, w_hold_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic [7:0]   aw_addr_r;
   logic [31:0]  w_data_r;
   logic [3:0]   w_strb_r;
   logic [1:0]   bresp_r, rresp_r;
   logic [31:0]  rdata_r;
   logic         mem_req_r, mem_we_r, mem_word_r;
   logic [15:0]  mem_addr_r, mem_wdata_r;

   // decode
   cdm_op_type   op;
   cdm_immw_type immw;
   logic         word_f, short_f, eff_word, is_load, is_store, is_mem, start_go;
   logic [3:0]   dst_f, src_f;
   logic [2:0]   ptr_idx;
   logic [15:0]  ptr_val, src_w, imm_v, disp_v, step_v, ea_c, move_v, load_v;
   logic         wr_fire;
   logic         wr_gr, wr_ok;

   assign op       = cdm_op_type'(insn_r[INSN_OP_LSB +: 4]);
   assign immw     = cdm_immw_type'(insn_r[INSN_IMMW_LSB +: 2]);
   assign word_f   = insn_r[INSN_WORD_BIT];
   assign short_f  = insn_r[INSN_SHORT_BIT];
   assign dst_f    = insn_r[INSN_DST_LSB +: 4];
   assign src_f    = insn_r[INSN_SRC_LSB +: 4];
   assign eff_word = word_f | (op == OP_POP) | (op == OP_PUSH);
   assign is_load  = (op == OP_LD_IND) | (op == OP_LD_DISP) | (op == OP_LD_INC)
                   | (op == OP_LD_ABS) | (op == OP_POP);
   assign is_store = (op == OP_ST_IND) | (op == OP_ST_DISP) | (op == OP_ST_DEC)
                   | (op == OP_ST_ABS) | (op == OP_PUSH);
   assign is_mem   = is_load | is_store;

   // push and pop take their pointer from the stack register; other loads from the source field, stores from the destination
   assign ptr_idx = ((op == OP_POP) | (op == OP_PUSH)) ? SP_IDX
                  : (is_load ? src_f[2:0] : dst_f[2:0]);
   assign ptr_val = gr_r[ptr_idx];
   assign src_w   = eff_word ? gr_r[src_f[2:0]]
                             : {8'h00, byte_of(gr_r[src_f[2:0]], src_f[3])};
   assign step_v  = eff_word ? 16'h0002 : 16'h0001;

   always_comb begin
      unique case (immw)
         IMMW_3:  imm_v = {13'h0000, opnd_r[2:0]};
         IMMW_8:  imm_v = {8'h00, opnd_r[7:0]};
         default: imm_v = opnd_r;
      endcase
   end

   // short displacement is sign-extended so it can reach below the base
   assign disp_v = short_f ? {{8{opnd_r[7]}}, opnd_r[7:0]} : opnd_r;

   always_comb begin
      unique case (op)
         OP_LD_DISP, OP_ST_DISP: ea_c = ptr_val + disp_v;
         OP_LD_ABS, OP_ST_ABS:   ea_c = short_f ? {SHORT_PAGE, opnd_r[7:0]}
                                                : opnd_r;
         OP_ST_DEC, OP_PUSH:     ea_c = ptr_val - step_v;
         default:                ea_c = ptr_val;
      endcase
   end

   assign move_v = (op == OP_MOV_IMM) ? (eff_word ? imm_v : {8'h00, imm_v[7:0]}) : src_w;
   assign load_v = eff_word ? mem_rdata : {8'h00, mem_rdata[7:0]};

   assign wr_fire  = aw_hold_r & w_hold_r & ~bvalid_r;
   assign wr_gr    = (aw_addr_r[7:5] == GR_PAGE);
   assign wr_ok    = wr_gr | (aw_addr_r == OFS_CTRL) | (aw_addr_r == OFS_INSN)
                   | (aw_addr_r == OFS_OPND) | (aw_addr_r == OFS_STAT)
                   | (aw_addr_r == OFS_COND);
   assign start_go = wr_fire & (aw_addr_r == OFS_CTRL) & w_strb_r[0]
                   & w_data_r[CTRL_START_BIT] & ~busy_r;

   // sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fsm_r    <= FS_IDLE;
         cnt_r    <= 3'h0;
         nstate_r <= NST_SHORT;
         busy_r   <= 1'b0;
      end else begin
         unique case (fsm_r)
            FS_IDLE: begin
               if (start_go) begin
                  fsm_r    <= FS_ADDR;
                  cnt_r    <= 3'h0;
                  busy_r   <= 1'b1;
                  nstate_r <= op_states(op, eff_word, short_f);
               end
            end
            FS_ADDR: begin
               cnt_r <= cnt_r + 3'h1;
               fsm_r <= is_mem ? FS_MEM : FS_FIN;
            end
            FS_MEM: begin
               cnt_r <= cnt_r + 3'h1;
               fsm_r <= FS_DATA;
            end
            FS_DATA: begin
               cnt_r <= cnt_r + 3'h1;
               fsm_r <= FS_FIN;
            end
            FS_FIN: begin
               // pad to the fixed state count so software sees fixed timing
               if (cnt_r >= nstate_r - 3'h1) begin
                  fsm_r  <= FS_IDLE;
                  busy_r <= 1'b0;
               end else begin
                  cnt_r <= cnt_r + 3'h1;
               end
            end
            default: begin
               fsm_r  <= FS_IDLE;
               busy_r <= 1'b0;
            end
         endcase
      end
   end

   // memory port
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mem_req_r   <= 1'b0;
         mem_we_r    <= 1'b0;
         mem_word_r  <= 1'b0;
         mem_addr_r  <= 16'h0000;
         mem_wdata_r <= 16'h0000;
      end else if (fsm_r == FS_ADDR && is_mem) begin
         mem_req_r   <= 1'b1;
         mem_we_r    <= is_store;
         mem_word_r  <= eff_word;
         // word accesses are forced even; an odd word pointer would split otherwise
         mem_addr_r  <= eff_word ? {ea_c[15:1], 1'b0} : ea_c;
         mem_wdata_r <= src_w;
      end else begin
         mem_req_r   <= 1'b0;
      end
   end

   // general registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 8; i++) gr_r[i] <= 16'h0000;
      end else if (busy_r) begin
         if (fsm_r == FS_ADDR) begin
            if (op == OP_MOV_IMM || op == OP_MOV_REG) begin
               if (eff_word) gr_r[dst_f[2:0]] <= move_v;
               else if (dst_f[3]) gr_r[dst_f[2:0]][7:0] <= move_v[7:0];
               else gr_r[dst_f[2:0]][15:8] <= move_v[7:0];
            end
            if (op == OP_ST_DEC || op == OP_PUSH)
               gr_r[ptr_idx] <= ea_c;
         end
         if (fsm_r == FS_DATA && is_load) begin
            if (op == OP_LD_INC || op == OP_POP)
               gr_r[ptr_idx] <= ptr_val + step_v;
            // loaded value wins when the pointer is also the destination
            if (eff_word) gr_r[dst_f[2:0]] <= load_v;
            else if (dst_f[3]) gr_r[dst_f[2:0]][7:0] <= load_v[7:0];
            else gr_r[dst_f[2:0]][15:8] <= load_v[7:0];
         end
      end else if (wr_fire && wr_gr) begin
         gr_r[aw_addr_r[4:2]] <= merge16(gr_r[aw_addr_r[4:2]], w_data_r[15:0], w_strb_r[1:0]);
      end
   end

   // condition codes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cond_r <= COND_RST;
      end else if (busy_r && fsm_r == FS_ADDR && !is_load) begin
         cond_r[COND_N_BIT] <= eff_word ? move_v[15] : move_v[7];
         cond_r[COND_Z_BIT] <= eff_word ? (move_v == 16'h0000)
                                        : (move_v[7:0] == 8'h00);
         cond_r[COND_V_BIT] <= 1'b0;
      end else if (busy_r && fsm_r == FS_DATA && is_load) begin
         cond_r[COND_N_BIT] <= eff_word ? load_v[15] : load_v[7];
         cond_r[COND_Z_BIT] <= (load_v == 16'h0000);
         cond_r[COND_V_BIT] <= 1'b0;
      end else if (!busy_r && wr_fire && aw_addr_r == OFS_COND && w_strb_r[0]) begin
         cond_r <= w_data_r[7:0];
      end
   end

   // instruction registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         insn_r <= 32'h0000_0000;
         opnd_r <= 16'h0000;
      end else if (wr_fire && !busy_r) begin
         // changing the instruction mid-flight would corrupt it, so writes while busy are dropped
         if (aw_addr_r == OFS_INSN) begin
            for (int b = 0; b < 4; b++)
               if (w_strb_r[b]) insn_r[8*b +: 8] <= w_data_r[8*b +: 8];
         end
         if (aw_addr_r == OFS_OPND)
            opnd_r <= merge16(opnd_r, w_data_r[15:0], w_strb_r[1:0]);
      end
   end

   // axi4-lite write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         awready_r <= 1'b0;
         aw_addr_r <= 8'h00;
      end else if (awvalid && awready_r) begin
         aw_hold_r <= 1'b1;
         awready_r <= 1'b0;
         aw_addr_r <= {awaddr[7:2], 2'h0};
      end else if (wr_fire) begin
         aw_hold_r <= 1'b0;
         awready_r <= 1'b1;
      end else begin
         awready_r <= ~aw_hold_r;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_hold_r <= 1'b0;
         wready_r <= 1'b0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else if (wvalid && wready_r) begin
         w_hold_r <= 1'b1;
         wready_r <= 1'b0;
         w_data_r <= wdata;
         w_strb_r <= wstrb;
      end else if (wr_fire) begin
         w_hold_r <= 1'b0;
         wready_r <= 1'b1;
      end else begin
         wready_r <= ~w_hold_r;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // axi4-lite read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         rresp_r   <= RESP_OKAY;
      end else if (arvalid && arready_r) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b1;
         rresp_r   <= RESP_OKAY;
         rdata_r   <= 32'h0000_0000;
         if (araddr[7:5] == GR_PAGE) begin
            rdata_r <= {16'h0000, gr_r[araddr[4:2]]};
         end else begin
            unique case ({araddr[7:2], 2'h0})
               OFS_CTRL: rdata_r <= 32'h0000_0000;
               OFS_INSN: rdata_r <= insn_r;
               OFS_OPND: rdata_r <= {16'h0000, opnd_r};
               OFS_STAT: rdata_r <= {28'h000_0000, cnt_r, busy_r};
               OFS_COND: rdata_r <= {24'h00_0000, cond_r};
               default:  rresp_r <= RESP_SLVERR;
            endcase
         end
      end else if (rvalid_r && rready) begin
         rvalid_r  <= 1'b0;
         arready_r <= 1'b1;
      end else begin
         arready_r <= ~rvalid_r;
      end
   end

   assign awready   = awready_r;
   assign wready    = wready_r;
   assign bvalid    = bvalid_r;
   assign bresp     = bresp_r;
   assign arready   = arready_r;
   assign rvalid    = rvalid_r;
   assign rdata     = rdata_r;
   assign rresp     = rresp_r;
   assign mem_req   = mem_req_r;
   assign mem_we    = mem_we_r;
   assign mem_word  = mem_word_r;
   assign mem_addr  = mem_addr_r;
   assign mem_wdata = mem_wdata_r;
   assign busy      = busy_r;

endmodule

`default_nettype wire

// ===== hdl/cdm_pkg.sv
// constants, field layout and state codes for the data-move execution unit
package cdm_pkg;

   // register byte offsets on the axi4-lite slave
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_INSN    = 8'h04;
   localparam logic [7:0] OFS_OPND    = 8'h08;
   localparam logic [7:0] OFS_STAT    = 8'h0C;
   localparam logic [7:0] OFS_COND    = 8'h10;
   localparam logic [2:0] GR_PAGE     = 3'h1;    // addr[7:5] of the general register window

   // instruction word fields
   localparam int unsigned INSN_OP_LSB    = 0;
   localparam int unsigned INSN_WORD_BIT  = 4;
   localparam int unsigned INSN_DST_LSB   = 8;
   localparam int unsigned INSN_SRC_LSB   = 12;
   localparam int unsigned INSN_IMMW_LSB  = 16;
   localparam int unsigned INSN_SHORT_BIT = 18;

   // control and status bits
   localparam int unsigned CTRL_START_BIT = 0;
   localparam int unsigned STAT_BUSY_BIT  = 0;

   // condition code bit positions and reset value
   localparam int unsigned COND_N_BIT = 3;
   localparam int unsigned COND_Z_BIT = 2;
   localparam int unsigned COND_V_BIT = 1;
   localparam logic [7:0]  COND_RST   = 8'h80;

   localparam logic [2:0]  SP_IDX    = 3'h7;
   localparam logic [7:0]  SHORT_PAGE = 8'hFF;   // upper byte of an 8-bit absolute address

   // execution state counts per instruction form
   localparam logic [2:0] NST_SHORT = 3'h2;
   localparam logic [2:0] NST_MID   = 3'h4;
   localparam logic [2:0] NST_LONG  = 3'h6;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      OP_MOV_IMM  = 4'h0,
      OP_MOV_REG  = 4'h1,
      OP_LD_IND   = 4'h2,
      OP_LD_DISP  = 4'h3,
      OP_LD_INC   = 4'h4,
      OP_LD_ABS   = 4'h5,
      OP_ST_IND   = 4'h6,
      OP_ST_DISP  = 4'h7,
      OP_ST_DEC   = 4'h8,
      OP_ST_ABS   = 4'h9,
      OP_POP      = 4'hA,
      OP_PUSH     = 4'hB
   } cdm_op_type;

   typedef enum logic [1:0] {
      IMMW_3  = 2'h0,
      IMMW_8  = 2'h1,
      IMMW_16 = 2'h2
   } cdm_immw_type;

   typedef enum logic [4:0] {
      FS_IDLE = 5'b00001,
      FS_ADDR = 5'b00010,
      FS_MEM  = 5'b00100,
      FS_DATA = 5'b01000,
      FS_FIN  = 5'b10000
   } cdm_fsm_type;

endpackage

// ===== test/cdm_data_move_assertions.sv
// checker for the data-move unit, seeing only its top-level ports
`timescale 1ns/1ps
`default_nettype none

module cdm_data_move_checker
   import cdm_pkg::*;
(
   input wire logic        aclk,      // system clock
   input wire logic        aresetn,   // synchronous reset, active low
   input wire logic        awvalid,   // write address valid
   input wire logic        awready,   // write address ready
   input wire logic [7:0]  araddr,    // read address
   input wire logic        arvalid,   // read address valid
   input wire logic        arready,   // read address ready
   input wire logic        rvalid,    // read data valid
   input wire logic [1:0]  rresp,     // read response
   input wire logic        mem_req,   // memory strobe
   input wire logic        mem_we,    // store
   input wire logic        mem_word,  // 16-bit access
   input wire logic [15:0] mem_addr,  // access address
   input wire logic [15:0] mem_wdata, // store data
   input wire logic        busy       // instruction under way
);
   logic [3:0] busy_cnt_r;

   // length of the current busy run, read at the edge where busy falls
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy_cnt_r <= 4'h0;
      end else begin
         busy_cnt_r <= busy ? busy_cnt_r + 4'h1 : 4'h0;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence load_wait;
      busy ##1 busy;
   endsequence

   sequence quiet_bus;
      !mem_req [*3];
   endsequence

   one_access_a: assert property (mem_req |=> quiet_bus)
      else $error("memory strobe repeated within one instruction");
   access_slot_a: assert property (mem_req |-> $past(busy) && !$past(busy, 2))
      else $error("memory strobe not in second busy cycle");
   access_busy_a: assert property (mem_req |-> load_wait)
      else $error("busy dropped around a memory access");
   word_even_a: assert property (mem_req && mem_word |-> !mem_addr[0])
      else $error("word access at odd address");
   byte_lane_a: assert property (mem_req && mem_we && !mem_word |-> mem_wdata[15:8] == 8'h00)
      else $error("byte store upper lane not zero");
   state_count_a: assert property ($fell(busy) |-> busy_cnt_r inside {4'h2, 4'h4, 4'h6})
      else $error("instruction length not 2, 4 or 6 states");
   read_answer_a: assert property (arvalid && arready |=> rvalid)
      else $error("read data not returned the cycle after address");
   aw_drop_a: assert property (awvalid && awready |=> !awready)
      else $error("write address ready held after handshake");
   unmapped_rd_a: assert property (arvalid && arready && araddr[7:6] != 2'b00
                                   |=> rvalid && rresp == RESP_SLVERR)
      else $error("unmapped read not refused");
endmodule

bind cdm_data_move cdm_data_move_checker u_chk (
   .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .araddr(araddr),
   .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rresp(rresp), .mem_req(mem_req),
   .mem_we(mem_we), .mem_word(mem_word), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
   .busy(busy)
);

`default_nettype wire

// ===== test/cdm_mem_model.sv
// on-chip memory seen by the data-move unit, one-cycle load latency
`timescale 1ns/1ps
`default_nettype none

module cdm_mem_model (
   input  wire logic        aclk,      // system clock
   input  wire logic        mem_req,   // access strobe
   input  wire logic        mem_we,    // store
   input  wire logic        mem_word,  // 16-bit access
   input  wire logic [15:0] mem_addr,  // access address
   input  wire logic [15:0] mem_wdata, // store data
   output var  logic [15:0] mem_rdata  // load data, the cycle after the strobe
);
   logic [7:0]  mem_r [0:65535];
   logic [15:0] hi_a;
   logic [15:0] lo_a;

   assign hi_a = {mem_addr[15:1], 1'b0};
   assign lo_a = {mem_addr[15:1], 1'b1};

   always @(posedge aclk) begin
      if (mem_req && mem_we && mem_word) begin
         mem_r[hi_a] <= mem_wdata[15:8];
         mem_r[lo_a] <= mem_wdata[7:0];
      end else if (mem_req && mem_we) begin
         mem_r[mem_addr] <= mem_wdata[7:0];
      end
      // byte loads carry junk in the upper lane; stale data keeps toggling
      if (mem_req && !mem_we) begin
         mem_rdata <= mem_word ? {mem_r[hi_a], mem_r[lo_a]} : {~mem_r[mem_addr], mem_r[mem_addr]};
      end else begin
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule

`default_nettype wire

// ===== test/test_cdm_data_move.sv
// testbench: data-move instructions driven over the register bus
`timescale 1ns/1ps
`default_nettype none

module test_cdm_data_move
   import cdm_pkg::*;
   ;
   logic        aclk     = 1'b0;
   logic        aresetn  = 1'b0;
   logic [7:0]  awaddr   = 8'h00;
   logic [7:0]  araddr   = 8'h00;
   logic        awvalid  = 1'b0;
   logic        wvalid   = 1'b0;
   logic        bready   = 1'b0;
   logic        arvalid  = 1'b0;
   logic        rready   = 1'b0;
   logic [31:0] wdata    = 32'h0000_0000;
   logic [3:0]  wstrb    = 4'hF;
   logic        awready, wready, bvalid, arready, rvalid, mem_req, mem_we, mem_word, busy;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] mem_addr, mem_wdata, mem_rdata;
   logic [31:0] run_len  = 32'h0000_0000;
   logic        was_busy = 1'b0;
   logic [15:0] imm_exp [3] = '{16'h0007, 16'h00FF, 16'hFFFF};
   int          failures = 0;
   int          compares = 0;

   cdm_data_move u_dut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .mem_req(mem_req), .mem_we(mem_we), .mem_word(mem_word), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .busy(busy));

   cdm_mem_model u_mem (
      .aclk(aclk), .mem_req(mem_req), .mem_we(mem_we), .mem_word(mem_word),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   initial begin
      forever #20 aclk = ~aclk;
   end

   // busy run length, kept apart from the bus tasks so no cycle is missed
   always @(posedge aclk) begin
      was_busy <= busy;
      if (busy) run_len <= was_busy ? run_len + 32'h1 : 32'h1;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 100);
      if (n >= 100) failures++;
      bready <= 1'b0;
      check(32'(bresp), 32'(er));
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 100);
      if (n >= 100) failures++;
      rready <= 1'b0;
      check(rdata, exp);
      check(32'(rresp), 32'(er));
   endtask

   task automatic grchk(input int idx, input logic [15:0] e);
      rchk(8'h20 + 8'(4 * idx), {16'h0000, e}, RESP_OKAY);
   endtask

   // flags are preset to all ones so a kept bit and a cleared overflow both show
   task automatic exec(input cdm_op_type op, input logic w, input logic [3:0] dst,
                       input logic [3:0] src, input logic [1:0] iw, input logic sh,
                       input logic [15:0] opnd, input logic [31:0] nst,
                       input logic nf, input logic zf);
      int n;
      n = 0;
      wr(OFS_COND, 32'h0000_00FF, RESP_OKAY);
      wr(OFS_INSN, {13'h0000, sh, iw, src, dst, 3'h0, w, op}, RESP_OKAY);
      wr(OFS_OPND, {16'h0000, opnd}, RESP_OKAY);
      wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
      while (busy !== 1'b1 && n < 20) begin
         @(posedge aclk);
         n++;
      end
      while (busy !== 1'b0 && n < 40) begin
         @(posedge aclk);
         n++;
      end
      if (n >= 40) failures++;
      check(run_len, nst);
      rchk(OFS_COND, {24'h00_0000, 4'hF, nf, zf, 2'b01}, RESP_OKAY);
   endtask

   task automatic conclude();
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // the whole sequence needs under a thousand cycles; this leaves ample margin
   initial begin
      repeat (30000) @(posedge aclk);
      failures++;
      conclude();
   end

   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(OFS_COND, 32'h0000_0080, RESP_OKAY);
      grchk(7, 16'h0000);
      rchk(8'h40, 32'h0000_0000, RESP_SLVERR);
      wr(8'h44, 32'h0000_0001, RESP_SLVERR);
      for (int i = 0; i < 3; i++) begin
         exec(OP_MOV_IMM, 1'b1, 4'h1, 4'h0, 2'(i), 1'b0, 16'hFFFF, 4, i == 2, 1'b0);
         grchk(1, imm_exp[i]);
      end
      exec(OP_MOV_IMM, 1'b0, 4'h9, 4'h0, IMMW_8, 1'b0, 16'h0000, 2, 1'b0, 1'b1);
      grchk(1, 16'hFF00);
      exec(OP_MOV_IMM, 1'b0, 4'h2, 4'h0, IMMW_8, 1'b0, 16'h0080, 2, 1'b1, 1'b0);
      grchk(2, 16'h8000);
      exec(OP_MOV_REG, 1'b0, 4'hB, 4'h2, IMMW_3, 1'b0, 16'h0000, 2, 1'b1, 1'b0);
      grchk(3, 16'h0080);
      exec(OP_MOV_REG, 1'b1, 4'h3, 4'h1, IMMW_3, 1'b0, 16'h0000, 2, 1'b1, 1'b0);
      grchk(3, 16'hFF00);
      exec(OP_MOV_IMM, 1'b1, 4'h5, 4'h0, IMMW_16, 1'b0, 16'h1002, 4, 1'b0, 1'b0);
      exec(OP_MOV_IMM, 1'b1, 4'h6, 4'h0, IMMW_16, 1'b0, 16'hA55A, 4, 1'b1, 1'b0);
      exec(OP_ST_DEC, 1'b1, 4'h5, 4'h6, IMMW_3, 1'b0, 16'h0000, 6, 1'b1, 1'b0);
      grchk(5, 16'h1000);
      exec(OP_ST_DEC, 1'b0, 4'h5, 4'hE, IMMW_3, 1'b0, 16'h0000, 6, 1'b0, 1'b0);
      grchk(5, 16'h0FFF);
      exec(OP_LD_INC, 1'b0, 4'hC, 4'h5, IMMW_3, 1'b0, 16'h0000, 6, 1'b0, 1'b0);
      grchk(4, 16'h005A);
      grchk(5, 16'h1000);
      exec(OP_LD_INC, 1'b1, 4'h4, 4'h5, IMMW_3, 1'b0, 16'h0000, 6, 1'b1, 1'b0);
      grchk(4, 16'hA55A);
      grchk(5, 16'h1002);
      exec(OP_MOV_IMM, 1'b1, 4'h7, 4'h0, IMMW_16, 1'b0, 16'h2000, 4, 1'b0, 1'b0);
      exec(OP_PUSH, 1'b1, 4'h0, 4'h6, IMMW_3, 1'b0, 16'h0000, 6, 1'b1, 1'b0);
      grchk(7, 16'h1FFE);
      exec(OP_POP, 1'b1, 4'h0, 4'h0, IMMW_3, 1'b0, 16'h0000, 6, 1'b1, 1'b0);
      grchk(0, 16'hA55A);
      grchk(7, 16'h2000);
      exec(OP_ST_DISP, 1'b1, 4'h5, 4'h1, IMMW_3, 1'b0, 16'h0010, 6, 1'b1, 1'b0);
      exec(OP_MOV_IMM, 1'b1, 4'h3, 4'h0, IMMW_16, 1'b0, 16'h1022, 4, 1'b0, 1'b0);
      exec(OP_LD_DISP, 1'b1, 4'h2, 4'h3, IMMW_3, 1'b1, 16'h00F0, 6, 1'b1, 1'b0);
      grchk(2, 16'hFF00);
      exec(OP_ST_ABS, 1'b0, 4'h0, 4'hE, IMMW_3, 1'b1, 16'h0034, 4, 1'b0, 1'b0);
      exec(OP_LD_ABS, 1'b0, 4'h0, 4'h0, IMMW_3, 1'b0, 16'hFF34, 6, 1'b0, 1'b0);
      grchk(0, 16'h5A5A);
      exec(OP_ST_IND, 1'b1, 4'h7, 4'h2, IMMW_3, 1'b0, 16'h0000, 4, 1'b1, 1'b0);
      exec(OP_LD_IND, 1'b0, 4'hD, 4'h7, IMMW_3, 1'b0, 16'h0000, 4, 1'b1, 1'b0);
      grchk(5, 16'h10FF);
      conclude();
   end
endmodule

`default_nettype wire
